// >>> icis_cfg.svh
// Offsets, field positions, reset values and timing counts
// Assumes a 12-bit byte offset below the card's memory window base
`ifndef ICIS_CFG_SVH
`define ICIS_CFG_SVH

// Register byte offsets, one aligned 32-bit word each
`define ICIS_OFF_MASTER_EN  12'h200
`define ICIS_OFF_REARM      12'h204
`define ICIS_OFF_SUMMARY    12'h208
`define ICIS_OFF_CHG_EN     12'h2ac
`define ICIS_OFF_CHG_FLAG   12'h2b0
`define ICIS_OFF_CHG_CLR    12'h2b4
`define ICIS_OFF_CNT_EN     12'h340
`define ICIS_OFF_CNT_CLR    12'h344
`define ICIS_OFF_CNT_FLAG   12'h348
`define ICIS_OFF_TMR_EN     12'h360
`define ICIS_OFF_TMR_CLR    12'h364
`define ICIS_OFF_TMR_FLAG   12'h368
`define ICIS_OFF_CAP_EN     12'h370
`define ICIS_OFF_CAP_CLR    12'h374
`define ICIS_OFF_CAP_FLAG   12'h378

// Field positions in the summary status word
`define ICIS_SUM_CHG        1
`define ICIS_SUM_CNT        4
`define ICIS_SUM_TMR        5
`define ICIS_SUM_OC         6

// Reset values
`define ICIS_RST_WIDE       16'h0000
`define ICIS_RST_NARROW     2'h0
`define ICIS_RST_WORD       32'h0000_0000

// Read data returns this many cycles after the read strobe
`define ICIS_READ_LAT       1

`endif

// >>> icis_flag_bank.sv
// Sticky flag word with per-bit enable and per-bit clear strobe
// Assumes event, enable and clear are synchronous to sys_clk_in
`timescale 1ns/100ps

module icis_flag_bank #(
    parameter int W = 16
) (
    input  wire logic         sys_clk_in,  // System clock
    input  wire logic         rst_in,      // Sync reset, high
    input  wire logic [W-1:0] evt_in,      // Event pulses
    input  wire logic [W-1:0] en_in,       // Enable mask
    input  wire logic [W-1:0] clr_in,      // Clear strobes
    output logic      [W-1:0] flags_out,   // Sticky flags
    output logic              set_out      // Some enabled event this cycle
);

    // Per-bit flags; an event in the clear cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge sys_clk_in) begin
                if (rst_in) begin
                    flags_out[gi] <= 1'b0;
                end else if (evt_in[gi] && en_in[gi]) begin
                    flags_out[gi] <= 1'b1; // [RULE18]
                end else if (clr_in[gi]) begin
                    flags_out[gi] <= 1'b0; // [RULE7]
                end
            end
        end
    endgenerate

    // Summary hint for the status word
    assign set_out = |(evt_in & en_in);

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    chk_flag_lands: assert property ( // [RULE6]
        (evt_in & en_in) != '0 |=> (flags_out & $past(evt_in & en_in)) == $past(evt_in & en_in))
        else $error("enabled event did not set its flag");
    chk_flag_clears: assert property ( // [RULE13]
        (clr_in & ~(evt_in & en_in)) != '0
        |=> (flags_out & $past(clr_in & ~(evt_in & en_in))) == '0)
        else $error("clear strobe did not reset its flag");
    chk_flag_holds: assert property ( // [RULE18]
        ((evt_in & en_in) == '0) && (clr_in == '0) |=> $stable(flags_out))
        else $error("flag moved without event or clear");

endmodule

// >>> icis_pkg.sv
// Types shared by the interrupt source block
// Assumes callers include icis_cfg.svh for the constants
package icis_pkg;

    // One register access from the host side
    typedef struct packed {
        logic [11:0] addr;   // Byte offset in the window
        logic        wr;     // Write strobe, one cycle
        logic        rd;     // Read strobe, one cycle
        logic [31:0] wdata;  // Write data
    } icis_req_type;

    // Event pulses from the peripherals
    typedef struct packed {
        logic [15:0] cnt;    // Counter events
        logic [1:0]  tmr;    // Timer events
        logic [1:0]  cap;    // Capture unit events
        logic        ocmp;   // Any output-compare unit event
    } icis_evt_type;

endpackage

// >>> icis_tb.sv
// Self-checking bench for the interrupt source block: register tasks,
// event pulses and expected values worked out from the register layout.
// Assumes icis_cfg.svh and icis_pkg are compiled ahead of this file.
`timescale 1ns/100ps
`include "icis_cfg.svh"

// Compare two values, count the check and report a mismatch at once
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module testbench;
    import icis_pkg::*;

    logic         sys_clk;    // 20 MHz bench clock
    logic         rst;        // Sync reset, high
    icis_req_type req;        // Register access request
    logic [15:0]  iso;        // Isolated input levels
    icis_evt_type evt;        // Peripheral event pulses
    logic [31:0]  rdata;      // Read data seen
    logic         rvalid;     // Read answer valid seen
    logic         irq;        // Host request seen
    int           err_count;  // Mismatches
    int           n_tests;    // Comparisons made
    logic [11:0]  offs [12];  // Registers that reset to zero

    icis_top icis_top_inst (
        .sys_clk_in     (sys_clk),
        .rst_in         (rst),
        .reg_req_in     (req),
        .iso_in_in      (iso),
        .evt_in         (evt),
        .reg_rdata_out  (rdata),
        .reg_rvalid_out (rvalid),
        .irq_out        (irq)
    );

    // Free-running clock, 50 ns period
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Print counts and verdict, then stop
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One-cycle write strobe; strobe drops at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk) req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge sys_clk) req.wr <= 1'b0;
    endtask

    // One-cycle read strobe; answer is checked 1 ns after the taking edge
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        @(posedge sys_clk) req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 32'h0000_0000};
        @(posedge sys_clk) req.rd <= 1'b0;
        #1;
        `CHK({nm, " valid"}, 1'b1, rvalid)
        `CHK(nm, e, rdata)
    endtask

    // Events stand one cycle; input levels hold, so a change stays put
    task automatic pulse(input icis_evt_type e, input logic [15:0] iso_v);
        @(posedge sys_clk) begin
            evt <= e;
            iso <= iso_v;
        end
        @(posedge sys_clk) evt <= '0;
        repeat (2) @(posedge sys_clk);
    endtask

    // Enable, fire, read sticky flags, partial clear, read again
    task automatic grp(input logic [11:0] ea, input logic [11:0] ca, input logic [11:0] fa,
                       input logic [15:0] en, input logic [15:0] ev, input logic [15:0] cl,
                       input int g);
        icis_evt_type e;
        e = '0;
        case (g)
            0: e.cnt = ev;             // Counter group
            1: e.tmr = ev[1:0];        // Timer group
            default: e.cap = ev[1:0];  // Capture group
        endcase
        wr(ea, {16'h0000, en});
        rd_chk(ea, {16'h0000, en}, "enable");
        rd_chk(fa, 32'h0000_0000, "flags before");
        pulse(e, iso);
        rd_chk(fa, {16'h0000, en & ev}, "flags");
        wr(ca, {16'h0000, cl});
        rd_chk(ca, 32'h0000_0000, "clear strobe");
        rd_chk(fa, {16'h0000, en & ev & ~cl}, "flags after clear");
        wr(ea, 32'h0000_0000);
    endtask

    // Hang guard, far beyond the under two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        summarize();
    end

    // Main sequence
    initial begin
        err_count = 0;
        n_tests   = 0;
        rst       = 1'b1;
        req       = '0;
        iso       = 16'h0000;
        evt       = '0;
        offs = '{`ICIS_OFF_MASTER_EN, `ICIS_OFF_SUMMARY, `ICIS_OFF_CHG_EN, `ICIS_OFF_CHG_FLAG,
                 `ICIS_OFF_CNT_EN, `ICIS_OFF_CNT_CLR, `ICIS_OFF_CNT_FLAG, `ICIS_OFF_TMR_EN,
                 `ICIS_OFF_TMR_FLAG, `ICIS_OFF_CAP_EN, `ICIS_OFF_CAP_CLR, `ICIS_OFF_CAP_FLAG};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);

        // Every mask, flag and summary starts at zero
        foreach (offs[i]) begin
            rd_chk(offs[i], `ICIS_RST_WORD, "reset value");
        end

        // Events and input changes with all masks locked are dropped;
        // output compare has no mask in this block, so the pulse holds it low here
        pulse('{cnt: 16'hffff, tmr: 2'h3, cap: 2'h3, ocmp: 1'b0}, 16'hffff);
        foreach (offs[i]) begin
            rd_chk(offs[i], `ICIS_RST_WORD, "locked events");
        end

        // Each group: enabled bits latch, masked counter bits do not, clear acts per bit
        grp(`ICIS_OFF_CNT_EN, `ICIS_OFF_CNT_CLR, `ICIS_OFF_CNT_FLAG,
            16'h8001, 16'hffff, 16'h0001, 0);
        grp(`ICIS_OFF_TMR_EN, `ICIS_OFF_TMR_CLR, `ICIS_OFF_TMR_FLAG,
            16'h0003, 16'h0003, 16'h0001, 1);
        grp(`ICIS_OFF_CAP_EN, `ICIS_OFF_CAP_CLR, `ICIS_OFF_CAP_FLAG,
            16'h0003, 16'h0001, 16'h0002, 2);

        // Change detect: a locked input is ignored, an enabled one latches
        wr(`ICIS_OFF_CHG_EN, 32'h0000_0004);
        rd_chk(`ICIS_OFF_CHG_EN, 32'h0000_0004, "change mask");
        pulse('0, iso ^ 16'h0008);
        rd_chk(`ICIS_OFF_CHG_FLAG, 32'h0000_0000, "change locked");
        pulse('0, iso ^ 16'h0004);
        rd_chk(`ICIS_OFF_CHG_FLAG, 32'h0000_0001, "change flag");
        wr(`ICIS_OFF_CHG_CLR, 32'h0000_0001);
        rd_chk(`ICIS_OFF_CHG_FLAG, 32'h0000_0000, "change cleared");
        rd_chk(`ICIS_OFF_CHG_CLR, 32'h0000_0000, "change clear");

        // Summary collects groups; host request waits for master enable
        pulse('{cnt: 16'h0000, tmr: 2'h0, cap: 2'h0, ocmp: 1'b1}, iso);
        rd_chk(`ICIS_OFF_SUMMARY, (32'h1 << `ICIS_SUM_CHG) | (32'h1 << `ICIS_SUM_CNT) |
               (32'h1 << `ICIS_SUM_TMR) | (32'h1 << `ICIS_SUM_OC), "summary");
        `CHK("irq locked", 1'b0, irq)
        wr(`ICIS_OFF_MASTER_EN, 32'h0000_0001);
        rd_chk(`ICIS_OFF_MASTER_EN, 32'h0000_0001, "master enable");
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("irq enabled", 1'b1, irq)
        wr(`ICIS_OFF_REARM, 32'h0000_0001);
        rd_chk(`ICIS_OFF_SUMMARY, 32'h0000_0000, "summary rearmed");
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("irq rearmed", 1'b0, irq)
        rd_chk(`ICIS_OFF_REARM, 32'h0000_0000, "rearm reads zero");
        rd_chk(12'h3fc, 32'h0000_0000, "unmapped");
        summarize();
    end
endmodule

// >>> icis_top.sv
// Interrupt sources of a digital I/O card: input change, counters,
// timers and capture units, with summary word and master gate.
// Assumes all inputs are synchronous to sys_clk_in.
`timescale 1ns/100ps
`include "icis_cfg.svh"

// Notes on behaviour
// [RULE1] Sixteen-bit change enable mask, resets zero
// [RULE2] Change flag bit 0 shows enabled change
// [RULE3] Writing one to change clear drops flag
// [RULE4] Clear strobes fall back to zero alone
// [RULE5] Sixteen-bit counter enable mask, resets zero
// [RULE6] Counter flag bit n set by counter n
// [RULE7] Counter clear bit one resets that flag
// [RULE8] Two-bit timer enable mask, resets zero
// [RULE9] Two-bit timer flags show timer events
// [RULE10] Timer clear bit one resets that flag
// [RULE11] Two-bit capture enable mask, resets zero
// [RULE12] Two-bit capture flags show capture events
// [RULE13] Capture clear bit one resets that flag
// [RULE14] Software writes zeros to reserved bits
// [RULE15] Master enable bit 0 gates host request
// [RULE16] Summary bits 1,4,5,6 show group events
// [RULE17] Re-arm write clears summary word
// [RULE18] Flags set only when enabled, stay sticky
module icis_top
    import icis_pkg::*;
(
    input  wire logic          sys_clk_in,    // 20 MHz system clock
    input  wire logic          rst_in,        // Sync reset, high
    input  wire icis_req_type  reg_req_in,    // Register access
    input  wire logic [15:0]   iso_in_in,     // Isolated input levels
    input  wire icis_evt_type  evt_in,        // Peripheral events
    output logic [31:0]        reg_rdata_out, // Read data
    output logic               reg_rvalid_out,// Read data valid
    output logic               irq_out        // Request to host
);

    // Offset match, used for every write strobe
    function automatic logic at(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // Write strobes per register
    logic wr_master;   // Master enable write
    logic wr_rearm;    // Re-arm write
    logic wr_chg_en;   // Change mask write
    logic wr_chg_clr;  // Change clear write
    logic wr_cnt_en;   // Counter mask write
    logic wr_cnt_clr;  // Counter clear write
    logic wr_tmr_en;   // Timer mask write
    logic wr_tmr_clr;  // Timer clear write
    logic wr_cap_en;   // Capture mask write
    logic wr_cap_clr;  // Capture clear write

    assign wr_master  = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_MASTER_EN);
    assign wr_rearm   = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_REARM);
    assign wr_chg_en  = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_CHG_EN);
    assign wr_chg_clr = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_CHG_CLR);
    assign wr_cnt_en  = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_CNT_EN);
    assign wr_cnt_clr = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_CNT_CLR);
    assign wr_tmr_en  = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_TMR_EN);
    assign wr_tmr_clr = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_TMR_CLR);
    assign wr_cap_en  = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_CAP_EN);
    assign wr_cap_clr = reg_req_in.wr && at(reg_req_in.addr, `ICIS_OFF_CAP_CLR);

    // Software-owned control state
    logic        master_en_q;  // Card-level gate
    logic [15:0] chg_en_q;     // Change enable mask
    logic [15:0] cnt_en_q;     // Counter enable mask
    logic [1:0]  tmr_en_q;     // Timer enable mask
    logic [1:0]  cap_en_q;     // Capture enable mask

    // Mask registers; reserved bits are simply not stored
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            master_en_q <= 1'b0;
            chg_en_q    <= `ICIS_RST_WIDE;
            cnt_en_q    <= `ICIS_RST_WIDE;
            tmr_en_q    <= `ICIS_RST_NARROW;
            cap_en_q    <= `ICIS_RST_NARROW;
        end else begin
            if (wr_master) begin
                master_en_q <= reg_req_in.wdata[0]; // [RULE15]
            end
            if (wr_chg_en) begin
                chg_en_q <= reg_req_in.wdata[15:0]; // [RULE1]
            end
            if (wr_cnt_en) begin
                cnt_en_q <= reg_req_in.wdata[15:0]; // [RULE5]
            end
            if (wr_tmr_en) begin
                tmr_en_q <= reg_req_in.wdata[1:0]; // [RULE8]
            end
            if (wr_cap_en) begin
                cap_en_q <= reg_req_in.wdata[1:0]; // [RULE11]
            end
        end
    end

    // Clear strobes, each alive for exactly one cycle
    logic        chg_clr_q;  // Change flag clear
    logic [15:0] cnt_clr_q;  // Counter flag clears
    logic [1:0]  tmr_clr_q;  // Timer flag clears
    logic [1:0]  cap_clr_q;  // Capture flag clears
    logic        rearm_q;    // Summary clear

    // Self-clearing: software never has to write zeros back
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            chg_clr_q <= 1'b0;
            cnt_clr_q <= `ICIS_RST_WIDE;
            tmr_clr_q <= `ICIS_RST_NARROW;
            cap_clr_q <= `ICIS_RST_NARROW;
            rearm_q   <= 1'b0;
        end else begin
            chg_clr_q <= wr_chg_clr && reg_req_in.wdata[0]; // [RULE3]
            cnt_clr_q <= wr_cnt_clr ? reg_req_in.wdata[15:0] : '0; // [RULE4]
            tmr_clr_q <= wr_tmr_clr ? reg_req_in.wdata[1:0] : '0; // [RULE10]
            cap_clr_q <= wr_cap_clr ? reg_req_in.wdata[1:0] : '0; // [RULE13]
            rearm_q   <= wr_rearm && reg_req_in.wdata[0]; // [RULE17]
        end
    end

    // Change detection against the previous sample
    logic [15:0] iso_prev_q;  // Last input sample
    logic        primed_q;    // Previous sample is valid
    logic        chg_evt;     // Enabled input changed

    // No change is reported on the first cycle after reset,
    // when the old sample is only the reset constant
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            iso_prev_q <= `ICIS_RST_WIDE;
            primed_q   <= 1'b0;
        end else begin
            iso_prev_q <= iso_in_in;
            primed_q   <= 1'b1;
        end
    end

    assign chg_evt = primed_q && (|((iso_in_in ^ iso_prev_q) & chg_en_q)); // [RULE1]

    // Flag banks, one per source group except output compare
    logic        chg_flag;   // Change flag
    logic [15:0] cnt_flags;  // Counter flags
    logic [1:0]  tmr_flags;  // Timer flags
    logic [1:0]  cap_flags;  // Capture flags
    logic        chg_set;    // Change flag setting now
    logic        cnt_set;    // Some counter flag setting
    logic        tmr_set;    // Some timer flag setting
    logic        cap_set;    // Some capture flag setting

    // Mask already applied in chg_evt, so enable is tied high
    icis_flag_bank #(.W(1)) u_chg (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .evt_in     (chg_evt),
        .en_in      (1'b1),
        .clr_in     (chg_clr_q),
        .flags_out  (chg_flag), // [RULE2]
        .set_out    (chg_set)
    );

    icis_flag_bank #(.W(16)) u_cnt (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .evt_in     (evt_in.cnt),
        .en_in      (cnt_en_q),
        .clr_in     (cnt_clr_q),
        .flags_out  (cnt_flags), // [RULE6]
        .set_out    (cnt_set)
    );

    icis_flag_bank #(.W(2)) u_tmr (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .evt_in     (evt_in.tmr),
        .en_in      (tmr_en_q),
        .clr_in     (tmr_clr_q),
        .flags_out  (tmr_flags), // [RULE9]
        .set_out    (tmr_set)
    );

    icis_flag_bank #(.W(2)) u_cap (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .evt_in     (evt_in.cap),
        .en_in      (cap_en_q),
        .clr_in     (cap_clr_q),
        .flags_out  (cap_flags), // [RULE12]
        .set_out    (cap_set)
    );

    // Summary word; bit 0 (edge source) is not built here
    logic sum_chg_q;  // Change group raised
    logic sum_cnt_q;  // Counter group raised
    logic sum_tmr_q;  // Timer group raised
    logic sum_oc_q;   // Output-compare group raised

    // Sticky until re-arm; a new event in the re-arm cycle wins
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sum_chg_q <= 1'b0;
            sum_cnt_q <= 1'b0;
            sum_tmr_q <= 1'b0;
            sum_oc_q  <= 1'b0;
        end else begin
            sum_chg_q <= chg_set || (sum_chg_q && !rearm_q); // [RULE16]
            sum_cnt_q <= cnt_set || (sum_cnt_q && !rearm_q);
            sum_tmr_q <= tmr_set || (sum_tmr_q && !rearm_q);
            sum_oc_q  <= evt_in.ocmp || (sum_oc_q && !rearm_q); // [RULE17]
        end
    end

    logic [31:0] summary;  // Assembled status word

    // Capture units have no summary bit of their own
    always_comb begin
        summary                = `ICIS_RST_WORD;
        summary[`ICIS_SUM_CHG] = sum_chg_q;
        summary[`ICIS_SUM_CNT] = sum_cnt_q;
        summary[`ICIS_SUM_TMR] = sum_tmr_q;
        summary[`ICIS_SUM_OC]  = sum_oc_q;
    end

    // Request to the host, held while gate open and summary nonzero
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= master_en_q && (summary != '0); // [RULE15]
        end
    end

    // Read mux; reserved bits and unmapped offsets read zero
    logic [31:0] rd_mux;  // Selected read word

    always_comb begin
        rd_mux = `ICIS_RST_WORD;
        case (reg_req_in.addr)
            `ICIS_OFF_MASTER_EN: begin
                rd_mux[0] = master_en_q;
            end
            `ICIS_OFF_SUMMARY: begin
                rd_mux = summary; // [RULE16]
            end
            `ICIS_OFF_CHG_EN: begin
                rd_mux[15:0] = chg_en_q;
            end
            `ICIS_OFF_CHG_FLAG: begin
                rd_mux[0] = chg_flag; // [RULE2]
            end
            `ICIS_OFF_CNT_EN: begin
                rd_mux[15:0] = cnt_en_q;
            end
            `ICIS_OFF_CNT_CLR: begin
                rd_mux[15:0] = cnt_clr_q;
            end
            `ICIS_OFF_CNT_FLAG: begin
                rd_mux[15:0] = cnt_flags;
            end
            `ICIS_OFF_TMR_EN: begin
                rd_mux[1:0] = tmr_en_q;
            end
            `ICIS_OFF_TMR_CLR: begin
                rd_mux[1:0] = tmr_clr_q;
            end
            `ICIS_OFF_TMR_FLAG: begin
                rd_mux[1:0] = tmr_flags; // [RULE9]
            end
            `ICIS_OFF_CAP_EN: begin
                rd_mux[1:0] = cap_en_q;
            end
            `ICIS_OFF_CAP_CLR: begin
                rd_mux[1:0] = cap_clr_q;
            end
            `ICIS_OFF_CAP_FLAG: begin
                rd_mux[1:0] = cap_flags; // [RULE12]
            end
            default: begin
                rd_mux = `ICIS_RST_WORD; // Write-only and unmapped
            end
        endcase
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out  <= `ICIS_RST_WORD;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out  <= reg_req_in.rd ? rd_mux : `ICIS_RST_WORD;
            reg_rvalid_out <= reg_req_in.rd;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // Steps of a clear: the write, then a quiet strobe cycle
    sequence s_chg_clear;
        (wr_chg_clr && reg_req_in.wdata[0]) ##1 !chg_evt;
    endsequence

    sequence s_rearm;
        (wr_rearm && reg_req_in.wdata[0]) ##1 !(chg_set || cnt_set || tmr_set || evt_in.ocmp);
    endsequence

    chk_chg_mask_write: assert property ( // [RULE1]
        wr_chg_en |=> chg_en_q == $past(reg_req_in.wdata[15:0]))
        else $error("change mask did not take written value");
    chk_chg_flag_set: assert property ( // [RULE2]
        chg_evt |=> chg_flag ##1 (chg_flag || $past(chg_clr_q)))
        else $error("enabled change not flagged");
    chk_chg_clear: assert property ( // [RULE3]
        s_chg_clear |=> !chg_flag)
        else $error("change flag survived its clear");
    chk_strobe_self: assert property ( // [RULE4]
        (cnt_clr_q != '0) && !wr_cnt_clr |=> cnt_clr_q == '0)
        else $error("counter clear strobe did not fall back");
    chk_cnt_mask_write: assert property ( // [RULE5]
        wr_cnt_en |=> cnt_en_q == $past(reg_req_in.wdata[15:0]))
        else $error("counter mask did not take written value");
    chk_tmr_mask_write: assert property ( // [RULE8]
        wr_tmr_en ##1 !wr_tmr_en |-> tmr_en_q == $past(reg_req_in.wdata[1:0]))
        else $error("timer mask did not take written value");
    chk_cap_mask_write: assert property ( // [RULE11]
        wr_cap_en |=> cap_en_q == $past(reg_req_in.wdata[1:0]))
        else $error("capture mask did not take written value");
    chk_irq_gate: assert property ( // [RULE15]
        !master_en_q |=> !irq_out)
        else $error("request raised while master gate closed");
    chk_irq_raise: assert property ( // [RULE15]
        master_en_q && sum_cnt_q |=> irq_out)
        else $error("request missing with gate open");
    chk_sum_groups: assert property ( // [RULE16]
        cnt_set |=> summary[`ICIS_SUM_CNT])
        else $error("counter event missing from summary");
    chk_sum_timer: assert property ( // [RULE16]
        tmr_set |=> summary[`ICIS_SUM_TMR])
        else $error("timer event missing from summary");
    chk_sum_rearm: assert property ( // [RULE17]
        s_rearm |=> summary == '0)
        else $error("summary not cleared by re-arm");

endmodule
